// ---- verilog/scpm_top.v ----
// system clock source selection and power mode control
// ==========================================================
//
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`include "scpm_consts.vh"
`default_nettype none
module scpm_top #(
    parameter ADDR_W = 4
) (
    input wire aclk,
    input wire aresetn,
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire halt_req,
    input wire wake_req,
    input wire watchdog_timeout,
    output wire pwm_source_clock_en,
    output wire high_speed_clock_en,
    output wire sub_clock_en,
    output wire slow_rc_clock_en,
    output wire sys_clock_en,
    output wire core_clock_en,
    output wire core_halted,
    output wire power_down_flag,
    output wire watchdog_timeout_flag,
    output wire fast_osc_stable_flag
);
    // ======================================================
    // modes
    localparam [2:0] MODE_FAST = 3'h0;
    localparam [2:0] MODE_SLOW = 3'h1;
    localparam [2:0] MODE_SLEEP = 3'h2;
    localparam [2:0] MODE_SUB_ONLY = 3'h3;
    localparam [2:0] MODE_ALL = 3'h4;
    localparam [2:0] MODE_FAST_ONLY = 3'h5;
    localparam [1:0] SW_IDLE = 2'h0;
    localparam [1:0] SW_OLD = 2'h1;
    localparam [1:0] SW_ARM = 2'h2;
    localparam [1:0] SW_GO = 2'h3;
    localparam [63:0] PWM_INC64 = `SCPM_PWM_INC;
    localparam [63:0] SLOW_INC64 = `SCPM_SLOW_INC;

    // ======================================================
    // control and status state
    reg [2:0] sel_r;
    reg fkeep_r;
    reg skeep_r;
    reg osc_en_r;
    reg halted_r;
    reg [2:0] mode_r;
    reg halt_fkeep_r;
    reg halt_skeep_r;
    reg pdf_r;
    reg tof_r;
    reg [4:0] stab_cnt_r;
    reg stable_r;
    reg hs_phase_r;
    reg [5:0] div_cnt_r;
    reg [2:0] sel_act_r;
    reg [1:0] sw_r;
    reg pwm_en_r;
    reg hs_en_r;
    reg sub_en_r;
    reg slow_en_r;
    reg sys_en_r;
    reg core_en_r;

    // ======================================================
    // oscillators
    wire pwm_tick;
    wire slow_tick;
    wire fast_run = osc_en_r & ~(halted_r & ~halt_fkeep_r);
    wire sub_run = ~(halted_r & ~halt_skeep_r);
    wire hs_tick = pwm_tick & hs_phase_r;

    scpm_rate_gen #(
        .INC(PWM_INC64[31:0])
    ) u_fast_rc (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(fast_run),
        .tick(pwm_tick)
    );

    // slow oscillator has no stop input: watchdog is always on
    scpm_rate_gen #(
        .INC(SLOW_INC64[31:0])
    ) u_slow_rc (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(1'b1),
        .tick(slow_tick)
    );

    wire sub_tick = slow_tick & sub_run;

    // ======================================================
    // divider and source picking
    function [5:0] div_mask;
        input [2:0] s;
        begin
            case (s)
                3'h0: div_mask = 6'h00;
                3'h1: div_mask = 6'h01;
                3'h2: div_mask = 6'h03;
                3'h3: div_mask = 6'h07;
                3'h4: div_mask = 6'h0F;
                3'h5: div_mask = 6'h1F;
                3'h6: div_mask = 6'h3F;
                default: div_mask = 6'h00;
            endcase
        end
    endfunction

    function src_tick;
        input [2:0] s;
        input hs;
        input sub;
        input [5:0] cnt;
        begin
            if (s == `SCPM_SEL_SUB)
                src_tick = sub;
            else
                src_tick = hs & ((cnt & div_mask(s)) == div_mask(s));
        end
    endfunction

    wire act_is_sub = (sel_act_r == `SCPM_SEL_SUB);
    wire old_tick = src_tick(sel_act_r, hs_tick, sub_tick, div_cnt_r);
    wire new_tick = src_tick(sel_r, hs_tick, sub_tick, div_cnt_r);
    wire sys_keep = ~halted_r | (act_is_sub ? halt_skeep_r : halt_fkeep_r);
    wire sys_tick = (sw_r == SW_GO) ? new_tick : ((sw_r == SW_ARM) ? 1'b0 : old_tick);

    // ======================================================
    // fast oscillator stability and divider counter
    always @(posedge aclk) begin
        if (!aresetn) begin
            stab_cnt_r <= 5'h00;
            stable_r <= 1'b0;
            hs_phase_r <= 1'b0;
            div_cnt_r <= 6'h00;
        end else if (!fast_run) begin
            stab_cnt_r <= 5'h00;
            stable_r <= 1'b0;
            hs_phase_r <= 1'b0;
        end else begin
            if (pwm_tick) begin
                hs_phase_r <= ~hs_phase_r;
            end
            if (hs_tick) begin
                div_cnt_r <= div_cnt_r + 6'h01;
                if (stab_cnt_r != `SCPM_STABLE_CNT) begin
                    stab_cnt_r <= stab_cnt_r + 5'h01;
                end
                if (stab_cnt_r == `SCPM_STABLE_CNT - 5'h01) begin
                    stable_r <= 1'b1;
                end
            end
        end
    end

    // ======================================================
    // glitch-free source switch
    // the first new edge after the last old edge is skipped, so the gap
    // across a switch is never shorter than one period of the new source
    always @(posedge aclk) begin
        if (!aresetn) begin
            sel_act_r <= `SCPM_SEL_RST;
            sw_r <= SW_IDLE;
        end else begin
            case (sw_r)
                SW_IDLE: begin
                    if (sel_r != sel_act_r) begin
                        sw_r <= SW_OLD;
                    end
                end
                SW_OLD: begin
                    if (sel_r == sel_act_r) begin
                        sw_r <= SW_IDLE;
                    end else if (old_tick) begin
                        sw_r <= SW_ARM;
                    end
                end
                SW_ARM: begin
                    if (new_tick) begin
                        sw_r <= SW_GO;
                    end
                end
                SW_GO: begin
                    if (new_tick) begin
                        sel_act_r <= sel_r;
                        sw_r <= SW_IDLE;
                    end
                end
                default: sw_r <= SW_IDLE;
            endcase
        end
    end

    // ======================================================
    // halt and wake
    always @(posedge aclk) begin
        if (!aresetn) begin
            halted_r <= 1'b0;
            halt_fkeep_r <= 1'b0;
            halt_skeep_r <= 1'b0;
            mode_r <= MODE_FAST;
        end else if (halted_r) begin
            if (wake_req) begin
                halted_r <= 1'b0;
                mode_r <= act_is_sub ? MODE_SLOW : MODE_FAST;
            end
        end else if (halt_req) begin
            halted_r <= 1'b1;
            halt_fkeep_r <= fkeep_r;
            halt_skeep_r <= skeep_r;
            case ({fkeep_r, skeep_r})
                2'b00: mode_r <= MODE_SLEEP;
                2'b01: mode_r <= MODE_SUB_ONLY;
                2'b11: mode_r <= MODE_ALL;
                default: mode_r <= MODE_FAST_ONLY;
            endcase
        end else begin
            mode_r <= act_is_sub ? MODE_SLOW : MODE_FAST;
        end
    end

    // ======================================================
    // clock enable outputs, all registered
    always @(posedge aclk) begin
        if (!aresetn) begin
            pwm_en_r <= 1'b0;
            hs_en_r <= 1'b0;
            sub_en_r <= 1'b0;
            slow_en_r <= 1'b0;
            sys_en_r <= 1'b0;
            core_en_r <= 1'b0;
        end else begin
            pwm_en_r <= pwm_tick;
            hs_en_r <= hs_tick;
            sub_en_r <= sub_tick;
            slow_en_r <= slow_tick;
            sys_en_r <= sys_tick & sys_keep;
            core_en_r <= sys_tick & ~halted_r;
        end
    end

    // ======================================================
    // axi4-lite slave
    reg awready_r;
    reg wready_r;
    reg bvalid_r;
    reg [1:0] bresp_r;
    reg arready_r;
    reg rvalid_r;
    reg [1:0] rresp_r;
    reg [31:0] rdata_r;
    reg [ADDR_W-1:0] awaddr_r;
    reg [31:0] wdata_r;
    reg [3:0] wstrb_r;
    reg aw_full_r;
    reg w_full_r;

    wire aw_hs = s_axi_awvalid & awready_r;
    wire w_hs = s_axi_wvalid & wready_r;
    wire ar_hs = s_axi_arvalid & arready_r;
    wire do_wr = aw_full_r & w_full_r & ~bvalid_r;
    wire wr_lane = wstrb_r[0];
    wire wr_sys = do_wr & wr_lane & (awaddr_r[3:0] == `SCPM_SYSCTL_ADDR);
    wire wr_osc = do_wr & wr_lane & (awaddr_r[3:0] == `SCPM_OSCCTL_ADDR);
    wire wr_sts = do_wr & wr_lane & (awaddr_r[3:0] == `SCPM_STATUS_ADDR);
    wire wr_hit = (awaddr_r[3:0] == `SCPM_SYSCTL_ADDR)
        | (awaddr_r[3:0] == `SCPM_OSCCTL_ADDR)
        | (awaddr_r[3:0] == `SCPM_STATUS_ADDR);
    wire slow_sel = (sel_r == `SCPM_SEL_SUB) & (sel_act_r == `SCPM_SEL_SUB);

    always @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            awaddr_r <= {ADDR_W{1'b0}};
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= `SCPM_RESP_OKAY;
        end else begin
            if (aw_hs) begin
                awaddr_r <= s_axi_awaddr;
                aw_full_r <= 1'b1;
                awready_r <= 1'b0;
            end
            if (w_hs) begin
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
                w_full_r <= 1'b1;
                wready_r <= 1'b0;
            end
            if (do_wr) begin
                aw_full_r <= 1'b0;
                w_full_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_hit ? `SCPM_RESP_OKAY : `SCPM_RESP_SLVERR;
            end
            if (bvalid_r & s_axi_bready) begin
                bvalid_r <= 1'b0;
                awready_r <= 1'b1;
                wready_r <= 1'b1;
            end
        end
    end

    // software registers; hardware sets win over write-one clears
    always @(posedge aclk) begin
        if (!aresetn) begin
            sel_r <= `SCPM_SEL_RST;
            fkeep_r <= `SCPM_FKEEP_RST;
            skeep_r <= `SCPM_SKEEP_RST;
            osc_en_r <= `SCPM_OSC_EN_RST;
            pdf_r <= 1'b0;
            tof_r <= 1'b0;
        end else begin
            if (wr_sys) begin
                sel_r <= wdata_r[`SCPM_SEL_HI:`SCPM_SEL_LO];
                fkeep_r <= wdata_r[`SCPM_FKEEP_BIT];
                skeep_r <= wdata_r[`SCPM_SKEEP_BIT];
            end
            // clearing the enable is refused unless fully in slow mode
            if (wr_osc & (wdata_r[`SCPM_OSC_EN_BIT] | slow_sel)) begin
                osc_en_r <= wdata_r[`SCPM_OSC_EN_BIT];
            end
            if (wr_sts & wdata_r[`SCPM_PDF_BIT]) begin
                pdf_r <= 1'b0;
            end
            if (wr_sts & wdata_r[`SCPM_TOF_BIT]) begin
                tof_r <= 1'b0;
            end
            if (halt_req & ~halted_r) begin
                pdf_r <= 1'b1;
                tof_r <= 1'b0;
            end
            if (watchdog_timeout) begin
                tof_r <= 1'b1;
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rresp_r <= `SCPM_RESP_OKAY;
            rdata_r <= 32'h00000000;
        end else if (ar_hs) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rresp_r <= `SCPM_RESP_OKAY;
            case (s_axi_araddr[3:0])
                `SCPM_SYSCTL_ADDR:
                    rdata_r <= {24'h000000, sel_r, 3'h0, fkeep_r, skeep_r};
                `SCPM_OSCCTL_ADDR:
                    rdata_r <= {30'h00000000, stable_r, osc_en_r};
                `SCPM_STATUS_ADDR:
                    rdata_r <= {23'h000000, (sw_r != SW_IDLE), sel_act_r,
                        mode_r, tof_r, pdf_r};
                default: begin
                    rdata_r <= 32'h00000000;
                    rresp_r <= `SCPM_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_r & s_axi_rready) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
        end
    end

    // ======================================================
    // outputs
    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;
    assign pwm_source_clock_en = pwm_en_r;
    assign high_speed_clock_en = hs_en_r;
    assign sub_clock_en = sub_en_r;
    assign slow_rc_clock_en = slow_en_r;
    assign sys_clock_en = sys_en_r;
    assign core_clock_en = core_en_r;
    assign core_halted = halted_r;
    assign power_down_flag = pdf_r;
    assign watchdog_timeout_flag = tof_r;
    assign fast_osc_stable_flag = stable_r;
endmodule
`default_nettype wire

// ---- verilog/scpm_consts.vh ----
// constants for the system clock and power mode controller
`ifndef SCPM_CONSTS_VH
`define SCPM_CONSTS_VH
// ==========================================================
// register byte offsets
`define SCPM_SYSCTL_ADDR 4'h0
`define SCPM_OSCCTL_ADDR 4'h4
`define SCPM_STATUS_ADDR 4'h8
// ==========================================================
// field positions and reset values
`define SCPM_SEL_HI 7
`define SCPM_SEL_LO 5
`define SCPM_FKEEP_BIT 1
`define SCPM_SKEEP_BIT 0
`define SCPM_OSC_EN_BIT 0
`define SCPM_OSC_STABLE_BIT 1
`define SCPM_PDF_BIT 0
`define SCPM_TOF_BIT 1
`define SCPM_SEL_RST 3'h1
`define SCPM_FKEEP_RST 1'h0
`define SCPM_SKEEP_RST 1'h0
`define SCPM_OSC_EN_RST 1'h1
`define SCPM_SEL_SUB 3'h7
// ==========================================================
// rates and timing
`define SCPM_ACLK_HZ 64'h7735940
`define SCPM_PWM_HZ 64'h1E84800
`define SCPM_FAST_RC_HZ 64'hF42400
`define SCPM_SLOW_RC_HZ 64'h7D00
`define SCPM_ACC_ONE 64'h100000000
`define SCPM_PWM_INC ((`SCPM_PWM_HZ * `SCPM_ACC_ONE) / `SCPM_ACLK_HZ)
`define SCPM_SLOW_INC ((`SCPM_SLOW_RC_HZ * `SCPM_ACC_ONE) / `SCPM_ACLK_HZ)
`define SCPM_STABLE_CNT 5'h10
`define SCPM_RESP_OKAY 2'h0
`define SCPM_RESP_SLVERR 2'h2
`endif

// ---- verilog/scpm_rate_gen.v ----
// fractional rate generator: one-cycle enable pulses at INC/2^32 of aclk
`default_nettype none
module scpm_rate_gen #(
    parameter [31:0] INC = 32'h00000001
) (
    input wire aclk,
    input wire aresetn,
    input wire run,
    output wire tick
);
    reg [31:0] acc_r;
    reg tick_r;
    wire [32:0] sum = {1'b0, acc_r} + {1'b0, INC};

    // phase is kept while stopped so a restart is not early
    always @(posedge aclk) begin
        if (!aresetn) begin
            acc_r <= 32'h00000000;
            tick_r <= 1'b0;
        end else if (run) begin
            acc_r <= sum[31:0];
            tick_r <= sum[32];
        end else begin
            tick_r <= 1'b0;
        end
    end

    assign tick = tick_r;
endmodule
`default_nettype wire

// ---- testbench/scpm_top_props.sv ----
// concurrent checks on the ports of the clock and power mode controller
`default_nettype none
module scpm_top_props (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire halt_req,
    input wire wake_req,
    input wire watchdog_timeout,
    input wire pwm_source_clock_en,
    input wire slow_rc_clock_en,
    input wire sys_clock_en,
    input wire core_clock_en,
    input wire core_halted,
    input wire power_down_flag,
    input wire watchdog_timeout_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ==========================================================
    // slow tick gap counter; wraps only long after the bound fires
    logic [12:0] slow_gap_r;
    logic [12:0] slow_gap_nxt;
    always @* slow_gap_nxt = slow_rc_clock_en ? 13'h0000 : slow_gap_r + 13'h0001;
    always @(posedge aclk) begin
        if (!aresetn) slow_gap_r <= 13'h0000;
        else slow_gap_r <= slow_gap_nxt;
    end
    // ==========================================================
    // assertions
    chk_slow_never_stops: assert property (slow_gap_r < 13'h0FA0)
        else $error("slow oscillator tick missing");
    chk_pwm_single_pulse: assert property (pwm_source_clock_en |=> !pwm_source_clock_en)
        else $error("pwm enable held two cycles");
    chk_core_stopped: assert property (core_halted && $past(core_halted) |-> !core_clock_en)
        else $error("core clock while halted");
    chk_core_from_sys: assert property (core_clock_en |-> sys_clock_en)
        else $error("core clock without system clock");
    chk_halt_entry: assert property (halt_req && !core_halted |=> core_halted && power_down_flag)
        else $error("halt entry not taken");
    chk_halt_tof_clear: assert property (halt_req && !core_halted && !watchdog_timeout
        |=> !watchdog_timeout_flag)
        else $error("timeout flag not cleared on halt");
    chk_tof_set: assert property (watchdog_timeout |=> watchdog_timeout_flag)
        else $error("timeout flag not set");
    chk_wake_exit: assert property (wake_req && core_halted |=> !core_halted)
        else $error("wake did not end halt");
    chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write address accepted with response pending");
    cov_halt: cover property (halt_req && !core_halted);
    cov_wake: cover property (wake_req && core_halted);
    cov_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind scpm_top scpm_top_props i_scpm_top_props (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .halt_req(halt_req), .wake_req(wake_req), .watchdog_timeout(watchdog_timeout),
    .pwm_source_clock_en(pwm_source_clock_en), .slow_rc_clock_en(slow_rc_clock_en),
    .sys_clock_en(sys_clock_en), .core_clock_en(core_clock_en), .core_halted(core_halted),
    .power_down_flag(power_down_flag), .watchdog_timeout_flag(watchdog_timeout_flag));
`default_nettype wire

// ---- testbench/scpm_top_tb.sv ----
// self-checking bench for the clock and power mode controller
`include "scpm_consts.vh"
`default_nettype none
module scpm_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} scpm_exp_t;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 32'h0, seed = 32'h171FB;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic halt_req = 1'b0, wake_req = 1'b0, watchdog_timeout = 1'b0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire pwm_source_clock_en, high_speed_clock_en, sub_clock_en, slow_rc_clock_en;
    wire sys_clock_en, core_clock_en, core_halted, power_down_flag;
    wire watchdog_timeout_flag, fast_osc_stable_flag;
    logic [31:0] c_pwm, c_hs, c_sys, c_core, c_sub;
    logic [2:0] mode_of [0:3] = '{3'h2, 3'h3, 3'h5, 3'h4};
    scpm_exp_t rq[$], bq[$], e;
    int mismatches = 0, n_tests = 0, k;
    localparam logic [1:0] OK = `SCPM_RESP_OKAY;
    localparam logic [1:0] ERR = `SCPM_RESP_SLVERR;
    scpm_top i_scpm_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .halt_req(halt_req), .wake_req(wake_req),
        .watchdog_timeout(watchdog_timeout), .pwm_source_clock_en(pwm_source_clock_en),
        .high_speed_clock_en(high_speed_clock_en), .sub_clock_en(sub_clock_en),
        .slow_rc_clock_en(slow_rc_clock_en), .sys_clock_en(sys_clock_en),
        .core_clock_en(core_clock_en), .core_halted(core_halted),
        .power_down_flag(power_down_flag), .watchdog_timeout_flag(watchdog_timeout_flag),
        .fast_osc_stable_flag(fast_osc_stable_flag));
    always #4 aclk = ~aclk;
    // ==========================================================
    // helpers
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic cmp(input logic [31:0] g, input logic [31:0] x, input logic [1:0] gr,
        input logic [1:0] xr);
        n_tests++;
        if (g !== x || gr !== xr) begin
            mismatches++;
            $display("mismatch at %0t got %h %h expected %h %h", $time, g, gr, x, xr);
        end
    endtask
    // rate counts jitter by a pulse or two since the enables are fractional
    task automatic near(input logic [31:0] g, input logic [31:0] x, input logic [31:0] t);
        cmp((g + t >= x && g <= x + t) ? x : g, x, OK, OK);
    endtask
    // waits as long as the slave needs; only the watchdog ends a hang
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        bq.push_back('{32'h0, 32'h0, r});
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [31:0] m,
        input logic [1:0] r);
        rq.push_back('{d, m, r});
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask
    task automatic cnt(input int n);
        c_pwm = 0;
        c_hs = 0;
        c_sys = 0;
        c_core = 0;
        c_sub = 0;
        repeat (n) begin
            @(posedge aclk);
            c_pwm += {31'h0, pwm_source_clock_en === 1'b1};
            c_hs += {31'h0, high_speed_clock_en === 1'b1};
            c_sys += {31'h0, sys_clock_en === 1'b1};
            c_core += {31'h0, core_clock_en === 1'b1};
            c_sub += {31'h0, sub_clock_en === 1'b1};
        end
    endtask
    // keep bits and select are set just before the halt; counts cover the halted span
    task automatic hc(input logic [2:0] sel, input logic [1:0] kp, input int n);
        wr(`SCPM_SYSCTL_ADDR, (xs() & 32'hFFFFFF1C) | {24'h0, sel, 3'h0, kp}, OK);
        @(posedge aclk);
        halt_req <= 1'b1;
        @(posedge aclk);
        halt_req <= 1'b0;
        rd(`SCPM_STATUS_ADDR, {27'h0, mode_of[kp], 2'h1}, 32'h1F, OK);
        cnt(n);
        cmp(c_core, 32'h0, OK, OK);
        repeat (xs() % 8) @(posedge aclk);
        wake_req <= 1'b1;
        @(posedge aclk);
        wake_req <= 1'b0;
        wr(`SCPM_STATUS_ADDR, 32'h3, OK);
        repeat (300) @(posedge aclk);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ==========================================================
    // response monitor
    always @(posedge aclk) begin
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
            e = rq.pop_front();
            cmp(s_axi_rdata & e.m, e.d, s_axi_rresp, e.r);
        end
        if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
            e = bq.pop_front();
            cmp(32'h0, 32'h0, s_axi_bresp, e.r);
        end
    end
    initial begin
        #600000;
        mismatches++;
        tally_and_finish();
    end
    // ==========================================================
    // main sequence
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`SCPM_SYSCTL_ADDR, 32'h20, 32'hE3, OK);
        rd(`SCPM_OSCCTL_ADDR, 32'h1, 32'h3, OK);
        rd(4'hC, 32'h0, 32'hFFFFFFFF, ERR);
        wr(4'hC, 32'h0, ERR);
        repeat (300) @(posedge aclk);
        rd(`SCPM_OSCCTL_ADDR, 32'h3, 32'h3, OK);
        wr(`SCPM_OSCCTL_ADDR, 32'h0, OK);
        rd(`SCPM_OSCCTL_ADDR, 32'h3, 32'h3, OK);
        @(posedge aclk);
        watchdog_timeout <= 1'b1;
        @(posedge aclk);
        watchdog_timeout <= 1'b0;
        rd(`SCPM_STATUS_ADDR, 32'h2, 32'h2, OK);
        for (k = 0; k < 4; k++) begin
            hc(3'h1, k[1:0], 64);
            cmp({31'h0, c_hs != 0}, {31'h0, k[1]}, OK, OK);
            cmp({31'h0, c_sys != 0}, {31'h0, k[1]}, OK, OK);
        end
        for (k = 0; k < 7; k++) begin
            wr(`SCPM_SYSCTL_ADDR, k << 5, OK);
            repeat (1500) @(posedge aclk);
            cnt(1024);
            near(c_sys, 131 >> k, 2);
            near(c_core, 131 >> k, 2);
            near(c_pwm, 262, 3);
            near(c_hs, 131, 2);
        end
        wr(`SCPM_SYSCTL_ADDR, 32'hE3, OK);
        repeat (12000) @(posedge aclk);
        rd(`SCPM_STATUS_ADDR, 32'hE4, 32'h1FC, OK);
        cnt(8000);
        near(c_sys, 2, 1);
        near(c_sub, 2, 1);
        hc(3'h7, 2'h1, 8000);
        near(c_sys, 2, 1);
        near(c_sub, 2, 1);
        hc(3'h7, 2'h2, 8000);
        cmp(c_sys, 32'h0, OK, OK);
        cmp(c_sub, 32'h0, OK, OK);
        near(c_hs, 1024, 3);
        wr(`SCPM_OSCCTL_ADDR, 32'h0, OK);
        // a tick launched just before the stop is still registered for two edges
        repeat (2) @(posedge aclk);
        cnt(200);
        cmp(c_pwm + c_hs, 32'h0, OK, OK);
        cmp({31'h0, fast_osc_stable_flag}, 32'h0, OK, OK);
        rd(`SCPM_OSCCTL_ADDR, 32'h0, 32'h3, OK);
        wr(`SCPM_OSCCTL_ADDR, 32'h1, OK);
        rd(`SCPM_OSCCTL_ADDR, 32'h1, 32'h3, OK);
        repeat (300) @(posedge aclk);
        rd(`SCPM_OSCCTL_ADDR, 32'h3, 32'h3, OK);
        repeat (4) @(posedge aclk);
        tally_and_finish();
    end
endmodule
`default_nettype wire
